// ===== viac_consts.vh
// How it works
// - Swapped phase selection acquires input during second clock phase.
// - Normal phase selection acquires input during first clock phase.
// - Resolution accepts only 7 through 13; host must not program others.
// - Writing resolution halts any conversion; host must start again.
// - Conversion is integrate window 2^(bits+2) periods, then the gap.
// - Counter, period timer and integrator column share one sample clock.
// - Signed format gives -2^(N-1) to 2^(N-1)-1 two's complement.
// - Unsigned format gives 0 to 2^N-1.
// - Power code: 0 off, 1 low, 2 medium, 3 high.
// - Analog block stays powered down until start or a power write gives nonzero power.
// - Power code may change while converting, without stop or restart.
// - Sample count command takes eight bits; zero runs continuously.
// - Completion sets data-available; next result overwrites an unread one.
`ifndef VIAC_CONSTS_VH
`define VIAC_CONSTS_VH
`define VIAC_ADDR_CTRL 8'h00
`define VIAC_ADDR_RES 8'h04
`define VIAC_ADDR_GAP 8'h08
`define VIAC_ADDR_POWER 8'h0C
`define VIAC_ADDR_START 8'h10
`define VIAC_ADDR_STATUS 8'h14
`define VIAC_ADDR_DATA 8'h18
`define VIAC_RES_MIN 4'd7
`define VIAC_RES_MAX 4'd13
`define VIAC_RES_RESET 4'd13
`define VIAC_GAP_RESET 16'h0005
`define VIAC_PWR_OFF 2'd0
`define VIAC_PWR_LOW 2'd1
`define VIAC_PWR_MED 2'd2
`define VIAC_PWR_HIGH 2'd3
`define VIAC_CTRL_PHASE 0
`define VIAC_CTRL_FMT 1
`define VIAC_CTRL_STOP 2
`define VIAC_CTRL_CLR 3
`define VIAC_ST_AVAIL 0
`define VIAC_ST_BUSY 1
`define VIAC_ST_INTEG 2
`define VIAC_RESP_OKAY 2'b00
`define VIAC_RESP_SLVERR 2'b10
`endif

// ===== viac_sync.v
`timescale 1ns/1ns
`default_nettype none
module viac_sync (
    input wire aclk,
    input wire aresetn,
    input wire d,
    output wire q
);
    reg meta_q;
    reg sync_q;
    always @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= d;
            sync_q <= meta_q;
        end
    end
    assign q = sync_q;
endmodule // viac_sync
`default_nettype wire

// ===== viac_format.v
`timescale 1ns/1ns
`default_nettype none
module viac_format (
    input wire [3:0] res,
    input wire fmt_signed,
    input wire [15:0] count,
    output reg [15:0] result
);
    // ****************************************
    // Window count 0..2^(N+2) mapped to N bits
    // ****************************************
    reg [15:0] scaled;
    reg [15:0] full;
    reg [15:0] half;
    always @* begin
        scaled = count >> 2;
        full = 16'h0001 << res;
        half = 16'h0001 << (res - 4'd1);
        if (scaled >= full) begin
            scaled = full - 16'h0001;
        end
        if (fmt_signed) begin
            result = scaled - half;
        end else begin
            result = scaled;
        end
    end
endmodule // viac_format
`default_nettype wire

// ===== viac_ctrl.v
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "viac_consts.vh"
module viac_ctrl (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire sample_clock,
    input wire comparator_positive,
    output reg acquire_phase1,
    output reg acquire_phase2,
    output reg integrator_reset,
    output reg [1:0] power_code,
    output reg data_available
);
    // ****************************************
    // States
    // ****************************************
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_INTEG = 3'b010;
    localparam [2:0] ST_GAP = 3'b100;

    reg [2:0] state_q;
    reg [3:0] res_q;
    reg [15:0] gap_q;
    reg phase_sel_q;
    reg fmt_signed_q;
    reg [7:0] remain_q;
    reg cont_q;
    reg [15:0] tick_q;
    reg [15:0] pos_q;
    reg [15:0] data_q;
    reg sclk_prev_q;
    reg [7:0] aw_q;
    reg aw_full_q;
    reg [31:0] w_q;
    reg [3:0] ws_q;
    reg w_full_q;
    wire sclk_s;
    wire comp_s;
    wire tick;
    wire [15:0] win_len;
    wire [15:0] fmt_res;
    wire wr_go;
    reg wr_ok;
    reg [31:0] rd_val;
    reg rd_ok;

    // ****************************************
    // Synchronisers and sample clock edge
    // ****************************************
    viac_sync u_sclk (
        .aclk(aclk),
        .aresetn(aresetn),
        .d(sample_clock),
        .q(sclk_s)
    );
    viac_sync u_comp (
        .aclk(aclk),
        .aresetn(aresetn),
        .d(comparator_positive),
        .q(comp_s)
    );
    // One tick drives counter, period timer and column alike
    assign tick = sclk_s & ~sclk_prev_q;
    assign win_len = 16'h0001 << (res_q + 4'd2);

    viac_format u_fmt (
        .res(res_q),
        .fmt_signed(fmt_signed_q),
        .count(pos_q),
        .result(fmt_res)
    );

    // ****************************************
    // Bus slave
    // ****************************************
    assign s_axi_awready = ~aw_full_q & ~s_axi_bvalid;
    assign s_axi_wready = ~w_full_q & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    assign wr_go = aw_full_q & w_full_q & ~s_axi_bvalid;

    always @* begin
        case (aw_q)
            `VIAC_ADDR_CTRL, `VIAC_ADDR_POWER, `VIAC_ADDR_START: wr_ok = 1'b1;
            `VIAC_ADDR_GAP: wr_ok = 1'b1;
            // Out of range resolution refused
            `VIAC_ADDR_RES: wr_ok = (w_q[3:0] >= `VIAC_RES_MIN) &&
                (w_q[3:0] <= `VIAC_RES_MAX) && (w_q[31:4] == 28'd0);
            default: wr_ok = 1'b0;
        endcase
    end

    always @* begin
        rd_ok = 1'b1;
        case (s_axi_araddr)
            `VIAC_ADDR_CTRL: rd_val = {30'd0, fmt_signed_q, phase_sel_q};
            `VIAC_ADDR_RES: rd_val = {28'd0, res_q};
            `VIAC_ADDR_GAP: rd_val = {16'd0, gap_q};
            `VIAC_ADDR_POWER: rd_val = {30'd0, power_code};
            `VIAC_ADDR_START: rd_val = {23'd0, cont_q, remain_q};
            `VIAC_ADDR_STATUS: rd_val = {29'd0, state_q[1],
                ~state_q[0], data_available};
            `VIAC_ADDR_DATA: rd_val = {16'd0, data_q};
            default: begin
                rd_val = 32'd0;
                rd_ok = 1'b0;
            end
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_q <= 8'h00;
            aw_full_q <= 1'b0;
            w_q <= 32'd0;
            ws_q <= 4'h0;
            w_full_q <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `VIAC_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `VIAC_RESP_OKAY;
            s_axi_rdata <= 32'd0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_q <= s_axi_awaddr;
                aw_full_q <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_q <= s_axi_wdata;
                ws_q <= s_axi_wstrb;
                w_full_q <= 1'b1;
            end
            if (wr_go) begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? `VIAC_RESP_OKAY : `VIAC_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_val;
                s_axi_rresp <= rd_ok ? `VIAC_RESP_OKAY : `VIAC_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ****************************************
    // Sequencer
    // ****************************************
    always @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= ST_IDLE;
            res_q <= `VIAC_RES_RESET;
            gap_q <= `VIAC_GAP_RESET;
            phase_sel_q <= 1'b0;
            fmt_signed_q <= 1'b1;
            power_code <= `VIAC_PWR_OFF;
            remain_q <= 8'd0;
            cont_q <= 1'b0;
            tick_q <= 16'd0;
            pos_q <= 16'd0;
            data_q <= 16'd0;
            data_available <= 1'b0;
            sclk_prev_q <= 1'b0;
            acquire_phase1 <= 1'b0;
            acquire_phase2 <= 1'b0;
            integrator_reset <= 1'b1;
        end else begin
            sclk_prev_q <= sclk_s;
            // Input acquired on phase one unless swapped
            acquire_phase1 <= state_q[1] & ~phase_sel_q;
            acquire_phase2 <= state_q[1] & phase_sel_q;
            integrator_reset <= ~state_q[1];
            case (state_q)
                ST_INTEG: begin
                    if (tick) begin
                        tick_q <= tick_q + 16'd1;
                        if (comp_s) begin
                            pos_q <= pos_q + 16'd1;
                        end
                        if (tick_q == win_len - 16'd1) begin
                            tick_q <= 16'd0;
                            state_q <= ST_GAP;
                        end
                    end
                end
                ST_GAP: begin
                    if (tick_q == 16'd0 && !tick) begin
                        data_q <= fmt_res;
                    end
                    if (tick) begin
                        tick_q <= tick_q + 16'd1;
                        if (tick_q + 16'd1 >= gap_q) begin
                            tick_q <= 16'd0;
                            pos_q <= 16'd0;
                            if (!cont_q && remain_q == 8'd1) begin
                                state_q <= ST_IDLE;
                            end else begin
                                state_q <= ST_INTEG;
                            end
                            if (!cont_q) begin
                                remain_q <= remain_q - 8'd1;
                            end
                        end
                    end
                end
                ST_IDLE: begin
                    tick_q <= 16'd0;
                    pos_q <= 16'd0;
                end
                default: state_q <= ST_IDLE;
            endcase
            // Flag set on completion; unread result overwritten
            if (state_q == ST_INTEG && tick && tick_q == win_len - 16'd1) begin
                data_available <= 1'b1;
            end else if (wr_go && aw_q == `VIAC_ADDR_CTRL &&
                    ws_q[0] && w_q[`VIAC_CTRL_CLR]) begin
                data_available <= 1'b0;
            end
            if (wr_go && wr_ok && ws_q[0]) begin
                case (aw_q)
                    `VIAC_ADDR_CTRL: begin
                        phase_sel_q <= w_q[`VIAC_CTRL_PHASE];
                        fmt_signed_q <= w_q[`VIAC_CTRL_FMT];
                        if (w_q[`VIAC_CTRL_STOP]) begin
                            state_q <= ST_IDLE;
                        end
                    end
                    `VIAC_ADDR_RES: begin
                        res_q <= w_q[3:0];
                        state_q <= ST_IDLE;
                    end
                    `VIAC_ADDR_GAP: begin
                        if (ws_q[1]) begin
                            gap_q <= w_q[15:0];
                        end
                    end
                    `VIAC_ADDR_POWER: begin
                        power_code <= w_q[1:0];
                    end
                    `VIAC_ADDR_START: begin
                        power_code <= w_q[9:8];
                        remain_q <= w_q[7:0];
                        cont_q <= (w_q[7:0] == 8'd0);
                        tick_q <= 16'd0;
                        pos_q <= 16'd0;
                        state_q <= (w_q[9:8] == `VIAC_PWR_OFF) ?
                            ST_IDLE : ST_INTEG;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end
endmodule // viac_ctrl
`default_nettype wire

// ===== viac_ctrl_monitor.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Port checker
// ****************************************
module viac_mon (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic acquire_phase1,
    input wire logic acquire_phase2,
    input wire logic integrator_reset,
    input wire logic [1:0] power_code,
    input wire logic data_available
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_ar;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_rhold;
        s_axi_rvalid && $stable(s_axi_rdata);
    endsequence
    property p_rans; s_ar |=> s_axi_rvalid; endproperty
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_rhold; endproperty
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
    endproperty
    property p_excl; !(acquire_phase1 && acquire_phase2); endproperty
    property p_idle;
        integrator_reset == !(acquire_phase1 || acquire_phase2);
    endproperty
    property p_nopwr;
        acquire_phase1 || acquire_phase2 |-> power_code != 2'h0;
    endproperty
    property p_avail; $rose(data_available) |-> ##[0:2] integrator_reset;
    endproperty
    property p_pwr; $changed(power_code) |-> ##[0:1] s_axi_bvalid;
    endproperty
    a_rans: assert property (p_rans) else $error("read answer late");
    a_rhold: assert property (p_rhold) else $error("read data dropped");
    a_bhold: assert property (p_bhold) else $error("write answer dropped");
    a_excl: assert property (p_excl) else $error("both phases on");
    a_idle: assert property (p_idle) else $error("reset mismatch");
    a_nopwr: assert property (p_nopwr) else $error("unpowered run");
    a_avail: assert property (p_avail) else $error("flag off window");
    a_pwr: assert property (p_pwr) else $error("power drift");
endmodule // viac_mon
bind viac_ctrl viac_mon u_mon (.*);
`default_nettype wire

// ===== tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "viac_consts.vh"
// ****************************************
// Bench
// ****************************************
module tb;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready, sample_clock, comparator_positive;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdv, ctl;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, power_code, rsp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, acquire_phase1, acquire_phase2, integrator_reset;
    logic data_available, s, p, c;
    int fail_count, cmp_count, sc, icnt, cyc, n, i0;
    viac_ctrl uut (.*);
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        sc <= (sc == 13) ? 0 : sc + 1;
        sample_clock <= (sc < 7);
        icnt <= icnt + (acquire_phase1 | acquire_phase2);
        cyc <= cyc + 1;
        if (cyc == 95000) begin
            fail_count++;
            stop_test;
        end
    end
    task stop_test;
        $display("Counts: compares=%0d mismatches=%0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task xf(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic dn;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_bready <= w;
        s_axi_arvalid <= !w;
        s_axi_rready <= !w;
        dn = 1'b0;
        while (!dn) begin
            @(posedge aclk);
            dn = w ? s_axi_bvalid : s_axi_rvalid;
            rsp = w ? s_axi_bresp : s_axi_rresp;
            rdv = s_axi_rdata;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
    endtask
    task wt(input int k);
        int m;
        logic [2:0] sel;
        m = 0;
        sel = 3'h0;
        while (m < 40000 && !sel[k]) begin
            @(negedge aclk);
            sel = {integrator_reset, data_available,
                   acquire_phase1 | acquire_phase2};
            m++;
        end
        if (!sel[k]) fail_count++;
    endtask
    function automatic logic [31:0] er(int b, logic sg, logic cp);
        int v;
        v = cp ? (1 << b) - 1 : 0;
        if (sg) v = v - (1 << (b - 1));
        return {16'h0000, v[15:0]};
    endfunction
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, comparator_positive} = 3'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        {s_axi_awprot, s_axi_arprot, s_axi_wstrb} = 10'h00F;
        {sc, icnt, cyc, fail_count, cmp_count} = '0;
        void'($urandom(33187));
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        chk({power_code, integrator_reset}, 32'h1);
        xf(0, `VIAC_ADDR_RES, 0); chk(rdv, 32'hD);
        for (int i = 0; i < 3; i++) begin
            n = (i == 0) ? 6 : (i == 1) ? 14 : 13;
            xf(1, `VIAC_ADDR_RES, n);
            chk(rsp, n == 13 ? `VIAC_RESP_OKAY : `VIAC_RESP_SLVERR);
        end
        xf(0, 8'h1C, 0); chk(rsp, `VIAC_RESP_SLVERR);
        xf(1, `VIAC_ADDR_GAP, 32'h14);
        for (n = 7; n < 10; n++) begin
            {s, p, c} = 3'($urandom);
            comparator_positive <= c;
            ctl = {30'h0000_0000, s, p};
            xf(1, `VIAC_ADDR_RES, n);
            xf(1, `VIAC_ADDR_CTRL, ctl);
            xf(1, `VIAC_ADDR_START, 32'h301); i0 = icnt;
            wt(0); chk({acquire_phase2, acquire_phase1}, p ? 2 : 1);
            wt(1); chk((icnt - i0 - (14 << (n + 2))) / 19, 0);
            xf(0, `VIAC_ADDR_DATA, 0); chk(rdv & 32'hFFFF, er(n, s, c));
            repeat (300) @(posedge aclk);
            xf(1, `VIAC_ADDR_CTRL, ctl | 32'h8);
            xf(0, `VIAC_ADDR_STATUS, 0); chk(rdv[2:0], 0);
        end
        xf(1, `VIAC_ADDR_RES, 7);
        comparator_positive <= 1'b1;
        xf(1, `VIAC_ADDR_START, 32'h200);
        wt(1);
        comparator_positive <= 1'b0;
        xf(1, `VIAC_ADDR_POWER, 1);
        @(negedge aclk); chk(power_code, 1);
        wt(0); wt(2); repeat (8) @(posedge aclk);
        xf(0, `VIAC_ADDR_DATA, 0); chk(rdv & 32'hFFFF, er(7, s, 0));
        xf(0, `VIAC_ADDR_STATUS, 0); chk(rdv[1:0], 3);
        xf(1, `VIAC_ADDR_RES, 8);
        xf(0, `VIAC_ADDR_STATUS, 0); chk(rdv[1], 0);
        xf(1, `VIAC_ADDR_CTRL, ctl | 32'h8);
        xf(1, `VIAC_ADDR_START, 32'h300);
        wt(0);
        xf(1, `VIAC_ADDR_CTRL, ctl | 32'h4);
        @(negedge aclk); chk(power_code, 3);
        repeat (7000) @(negedge aclk);
        chk({data_available, acquire_phase1, acquire_phase2}, 0);
        stop_test;
    end
endmodule // tb
`default_nettype wire
